//--- rtl/periodic_interrupt_timer.sv
// Purpose: periodic interrupt timer with an AHB-Lite register slave
// Assumes: single word transfers; register data in the low byte
// Notes: every access takes one wait state so read data come from a flop
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ns
`include "timer_defines.svh"

module periodic_interrupt_timer #(
    parameter int EV_WIDTH = 2
) (
    input logic hclk,
    input logic hresetn,
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [2:0] hsize,
    input logic [31:0] hwdata,
    input logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    output logic irq
);

    generate
        if (EV_WIDTH < 2 || EV_WIDTH > 8) begin : g_chk
            $error("event width must be 2 to 8");
        end
    endgenerate

    // ==========================================================
    // declarations
    timer_pkg::bus_state_type state_r;
    logic [7:0] idx_r;
    logic wr_r;
    logic map_ok_r;
    logic hreadyout_r;
    logic [31:0] hrdata_r;
    logic hresp_r;
    logic irq_r;

    logic flag_r;
    logic ie_r;
    logic halt_r;
    logic [2:0] psel_r;
    logic arm_r;
    logic [15:0] count_r;
    logic [7:0] limit_hi_r;
    logic [7:0] limit_lo_r;
    logic hold_r;
    logic lat_r;
    logic [7:0] low_buf_r;

    logic accept;
    logic acc;
    logic rd;
    logic wr;
    logic [7:0] wdat;
    logic [7:0] rd_byte;
    logic rd_sc;
    logic wr_sc;
    logic rd_hi;
    logic rd_lo;
    logic wr_cnt;
    logic clr_req;
    logic tick;
    logic at_limit;
    logic ovf;
    logic ovf_ev;
    logic [15:0] limit;
    logic [EV_WIDTH-1:0] ev_in;
    logic [EV_WIDTH-1:0] ev_status;
    logic [EV_WIDTH-1:0] ev_mask;
    logic ev_pending;
    // a literal cannot be bit-selected, so the reset word is held as a constant
    localparam logic [7:0] sc_reset_value = `SC_RESET;

    // ==========================================================
    // bus slave
    assign accept = hsel && htrans[1] && hready && (state_r == timer_pkg::bus_idle);
    assign acc = (state_r == timer_pkg::bus_wait);
    assign rd = acc && !wr_r && map_ok_r;
    assign wr = acc && wr_r && map_ok_r;
    assign wdat = hwdata[7:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= timer_pkg::bus_idle;
            hreadyout_r <= 1'b1;
        end else if (accept) begin
            state_r <= timer_pkg::bus_wait;
            hreadyout_r <= 1'b0;
        end else if (acc) begin
            state_r <= timer_pkg::bus_idle;
            hreadyout_r <= 1'b1;
        end
    end

    // only word transfers are served, so hsize is not decoded
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idx_r <= 8'h00;
            wr_r <= 1'b0;
            map_ok_r <= 1'b0;
        end else if (accept) begin
            idx_r <= haddr[9:2];
            wr_r <= hwrite;
            map_ok_r <= (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
        end
    end

    assign rd_sc = rd && (idx_r == `IDX_STATUS_CONTROL);
    assign wr_sc = wr && (idx_r == `IDX_STATUS_CONTROL);
    assign rd_hi = rd && (idx_r == `IDX_COUNTER_HIGH);
    assign rd_lo = rd && (idx_r == `IDX_COUNTER_LOW);
    assign wr_cnt = wr && (idx_r == `IDX_COUNTER_HIGH || idx_r == `IDX_COUNTER_LOW);

    always_comb begin
        rd_byte = 8'h00;
        case (idx_r)
            `IDX_STATUS_CONTROL: rd_byte = {flag_r, ie_r, halt_r, 2'b00, psel_r};
            `IDX_COUNTER_HIGH: rd_byte = count_r[15:8];
            `IDX_COUNTER_LOW: rd_byte = lat_r ? low_buf_r : count_r[7:0];
            `IDX_LIMIT_HIGH: rd_byte = limit_hi_r;
            `IDX_LIMIT_LOW: rd_byte = limit_lo_r;
            `IDX_EVENT_STATUS: rd_byte = 8'(ev_status);
            `IDX_EVENT_MASK: rd_byte = 8'(ev_mask);
            default: rd_byte = 8'h00;
        endcase
    end

    // unmapped reads return zero, writes there are dropped, answer stays OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0000_0000;
        end else if (acc) begin
            hrdata_r <= rd ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp_r <= 1'b0;
        end else begin
            hresp_r <= 1'b0;
        end
    end

    // ==========================================================
    // status and control
    assign clr_req = wr_sc && wdat[`SC_CLEAR];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ie_r <= sc_reset_value[`SC_IRQ_EN];
            halt_r <= sc_reset_value[`SC_HALT];
            psel_r <= sc_reset_value[`SC_PS_MSB:`SC_PS_LSB];
        end else if (wr_sc) begin
            ie_r <= wdat[`SC_IRQ_EN];
            halt_r <= wdat[`SC_HALT];
            psel_r <= wdat[`SC_PS_MSB:`SC_PS_LSB];
        end
    end

    // a fresh overflow disarms the clear, so a stale read cannot lose it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            arm_r <= 1'b0;
        end else if (ovf_ev) begin
            arm_r <= 1'b0;
        end else if (rd_sc && flag_r) begin
            arm_r <= 1'b1;
        end else if (wr_sc) begin
            arm_r <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_r <= sc_reset_value[`SC_FLAG];
        end else if (ovf_ev) begin
            flag_r <= 1'b1;
        end else if (wr_sc && !wdat[`SC_FLAG] && arm_r) begin
            flag_r <= 1'b0;
        end
    end

    // ==========================================================
    // limit registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            limit_hi_r <= `LIMIT_RESET;
            limit_lo_r <= `LIMIT_RESET;
        end else if (wr && idx_r == `IDX_LIMIT_HIGH) begin
            limit_hi_r <= wdat;
        end else if (wr && idx_r == `IDX_LIMIT_LOW) begin
            limit_lo_r <= wdat;
        end
    end

    // half-written limit would give a false overflow, so flag waits for the low byte
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_r <= 1'b0;
        end else if (wr && idx_r == `IDX_LIMIT_HIGH) begin
            hold_r <= 1'b1;
        end else if (wr && idx_r == `IDX_LIMIT_LOW) begin
            hold_r <= 1'b0;
        end
    end

    assign limit = {limit_hi_r, limit_lo_r};

    // ==========================================================
    // counter
    prescaler #(
        .DIV_BITS(6)
    ) u_prescaler (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(!halt_r),
        .clear(clr_req),
        .sel(psel_r),
        .tick(tick)
    );

    assign at_limit = (count_r == limit);
    assign ovf = tick && at_limit && !clr_req;
    assign ovf_ev = ovf && !hold_r;

    // counting depends only on tick and clear, never on bus reads
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_r <= `COUNT_RESET;
        end else if (clr_req) begin
            count_r <= `COUNT_RESET;
        end else if (tick) begin
            count_r <= at_limit ? `COUNT_RESET : count_r + 16'h0001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lat_r <= 1'b0;
            low_buf_r <= 8'h00;
        end else if (rd_hi && !lat_r) begin
            lat_r <= 1'b1;
            low_buf_r <= count_r[7:0];
        end else if (rd_lo) begin
            lat_r <= 1'b0;
        end
    end

    // ==========================================================
    // interrupt
    assign ev_in = EV_WIDTH'({clr_req, ovf_ev});

    event_flags #(
        .WIDTH(EV_WIDTH)
    ) u_events (
        .hclk(hclk),
        .hresetn(hresetn),
        .event_in(ev_in),
        .rd_clear(rd && idx_r == `IDX_EVENT_STATUS),
        .mask_we(wr && idx_r == `IDX_EVENT_MASK),
        .mask_wdata(wdat[EV_WIDTH-1:0]),
        .status(ev_status),
        .mask(ev_mask),
        .pending(ev_pending)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= (flag_r && ie_r) || ev_pending;
        end
    end

    assign hreadyout = hreadyout_r;
    assign hrdata = hrdata_r;
    assign hresp = hresp_r;
    assign irq = irq_r;

    // ==========================================================
    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_wait_state;
        !hreadyout_r ##1 hreadyout_r;
    endsequence

    property p_one_wait;
        accept |=> s_wait_state;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("access not one wait state");

    property p_wrap;
        tick && at_limit && !clr_req |=> count_r == 16'h0000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap at limit");

    property p_count_up;
        tick && !at_limit && !clr_req |=> count_r == $past(count_r) + 16'h0001;
    endproperty
    a_count_up: assert property (p_count_up) else $error("counter did not step up");

    property p_quiet;
        !tick && !clr_req |=> $stable(count_r);
    endproperty
    a_quiet: assert property (p_quiet) else $error("counter moved without tick");

    property p_read_free;
        (rd_hi || rd_lo || wr_cnt) && !tick && !clr_req |=> $stable(count_r);
    endproperty
    a_read_free: assert property (p_read_free) else $error("access disturbed counter");

    property p_halt;
        halt_r |-> !tick;
    endproperty
    a_halt: assert property (p_halt) else $error("halted counter ticked");

    property p_sc_read;
        rd_sc |=> hrdata_r[`SC_CLEAR] == 1'b0 && hrdata_r[`SC_ZERO] == 1'b0;
    endproperty
    a_sc_read: assert property (p_sc_read) else $error("clear or bit 3 read one");

    property p_clear;
        clr_req |=> count_r == 16'h0000 && $stable(limit) && $stable(ev_mask);
    endproperty
    a_clear: assert property (p_clear) else $error("counter clear failed");

    sequence s_armed_write;
        arm_r && wr_sc && !wdat[`SC_FLAG] && !ovf_ev;
    endsequence

    property p_flag_clear;
        s_armed_write |=> !flag_r;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

    property p_flag_set;
        ovf_ev |=> flag_r ##1 (flag_r || $past(wr_sc));
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("overflow flag lost");

    sequence s_high_read;
        rd_hi && !lat_r;
    endsequence

    property p_latch;
        s_high_read |=> lat_r && low_buf_r == $past(count_r[7:0]);
    endproperty
    a_latch: assert property (p_latch) else $error("low byte not latched");

    property p_latch_keep;
        lat_r && !rd_lo |=> $stable(low_buf_r);
    endproperty
    a_latch_keep: assert property (p_latch_keep) else $error("latched low byte changed");

    property p_irq;
        flag_r && ie_r |=> irq_r;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

    property p_irq_drop;
        !(flag_r && ie_r) && !ev_pending |=> !irq_r;
    endproperty
    a_irq_drop: assert property (p_irq_drop) else $error("interrupt not dropped");

    property p_limit_read;
        rd && idx_r == `IDX_LIMIT_LOW |=> hrdata_r[7:0] == $past(limit_lo_r);
    endproperty
    a_limit_read: assert property (p_limit_read) else $error("limit low misread");

endmodule

//--- common/timer_defines.svh
// Purpose: offsets, field positions and reset values of the periodic interrupt timer
// Assumes: included by bare name; word index times four is the byte address
// Notes: the package holds the types
//
// What this block does
// - 16-bit up-counter, free or modulo wrap.
// - wrap limit from two byte limit registers.
// - counter reads never disturb counting.
// - counter clocked only by internal prescaler.
// - status/control bit layout, bit3 reads zero.
// - reset clears status/control except halt set.
// - counter bytes read-only, zero after reset.
// - both limit bytes reset to all ones.
// - seven registers at consecutive indices.
// - prescale codes divide by 1..64, 111=64.
// - overflow flag set; read-then-write-zero clears.
// - clear bit zeroes counter and prescaler, self-clears.
// - high read latches low byte until read.
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// ==========================================================
// register indices
`define IDX_STATUS_CONTROL 8'h4b
`define IDX_COUNTER_HIGH 8'h4c
`define IDX_COUNTER_LOW 8'h4d
`define IDX_LIMIT_HIGH 8'h4e
`define IDX_LIMIT_LOW 8'h4f
`define IDX_EVENT_STATUS 8'h50
`define IDX_EVENT_MASK 8'h51

// ==========================================================
// status/control fields
`define SC_FLAG 7
`define SC_IRQ_EN 6
`define SC_HALT 5
`define SC_CLEAR 4
`define SC_ZERO 3
`define SC_PS_MSB 2
`define SC_PS_LSB 0

// ==========================================================
// event status bits
`define EV_OVERFLOW 0
`define EV_CLEARED 1

// ==========================================================
// reset values
`define SC_RESET 8'h20
`define COUNT_RESET 16'h0000
`define LIMIT_RESET 8'hff
`define EV_MASK_RESET 8'h00

`endif

//--- common/timer_pkg.sv
// Purpose: types and shared decode for the periodic interrupt timer
// Assumes: used by package::name only
// Notes: prescale mask holds ones below the selected divider bit
package timer_pkg;

    typedef enum logic {bus_idle, bus_wait} bus_state_type;

    // codes 6 and 7 both give divide by 64
    function automatic logic [5:0] prescale_mask(input logic [2:0] sel);
        logic [5:0] m;
        m = 6'h00;
        case (sel)
            3'h0: m = 6'h00;
            3'h1: m = 6'h01;
            3'h2: m = 6'h03;
            3'h3: m = 6'h07;
            3'h4: m = 6'h0f;
            3'h5: m = 6'h1f;
            default: m = 6'h3f;
        endcase
        return m;
    endfunction

endpackage

//--- rtl/prescaler.sv
// Purpose: divides the bus clock into a one-cycle counting enable
// Assumes: clear and run come from logic on hclk
// Notes: tick is combinational from the divider register
`timescale 1ns/1ns

module prescaler #(
    parameter int DIV_BITS = 6
) (
    input logic hclk,
    input logic hresetn,
    input logic run,
    input logic clear,
    input logic [2:0] sel,
    output logic tick
);

    generate
        if (DIV_BITS < 6) begin : g_chk
            $error("prescaler needs at least six divider bits");
        end
    endgenerate

    logic [DIV_BITS-1:0] div_r;
    logic [DIV_BITS-1:0] mask;

    assign mask = DIV_BITS'(timer_pkg::prescale_mask(sel));
    assign tick = run && !clear && ((div_r & mask) == mask);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_r <= '0;
        end else if (clear) begin
            div_r <= '0;
        end else if (run) begin
            div_r <= div_r + 1'b1;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_div_one;
        run && !clear && sel == 3'h0 |-> tick;
    endproperty
    a_div_one: assert property (p_div_one) else $error("divide by one missed a tick");

    property p_div_top;
        tick && sel[2:1] == 2'b11 |-> div_r[5:0] == 6'h3f;
    endproperty
    a_div_top: assert property (p_div_top) else $error("codes 6 and 7 not divide by 64");

endmodule

//--- rtl/event_flags.sv
// Purpose: sticky event bits, mask and one pending level
// Assumes: rd_clear is a one-cycle read strobe of the status register
// Notes: an event in the clearing cycle survives the clear
`timescale 1ns/1ns
`include "timer_defines.svh"

module event_flags #(
    parameter int WIDTH = 2
) (
    input logic hclk,
    input logic hresetn,
    input logic [WIDTH-1:0] event_in,
    input logic rd_clear,
    input logic mask_we,
    input logic [WIDTH-1:0] mask_wdata,
    output logic [WIDTH-1:0] status,
    output logic [WIDTH-1:0] mask,
    output logic pending
);

    generate
        if (WIDTH < 1 || WIDTH > 8) begin : g_chk
            $error("event width must be 1 to 8");
        end
    endgenerate

    logic [WIDTH-1:0] status_r;
    logic [WIDTH-1:0] mask_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_r <= '0;
        end else begin
            status_r <= (rd_clear ? '0 : status_r) | event_in;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_r <= WIDTH'(`EV_MASK_RESET);
        end else if (mask_we) begin
            mask_r <= mask_wdata;
        end
    end

    assign status = status_r;
    assign mask = mask_r;
    assign pending = |(status_r & mask_r);

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_set_wins;
        |event_in |=> (status_r & $past(event_in)) == $past(event_in);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost against clear");

endmodule

//--- verification/ahb_master.sv
// Purpose: cpu-side bus master for the timer register slave
// Assumes: one slave, hready is that slave's hreadyout
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/1ns

module ahb_master (
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h0;
        hwdata = 32'h0;
    end

    // ==========================================================
    // single word transfer, waits on hready with no fixed latency
    task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= addr;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        haddr <= ~addr;
        hwdata <= wdata;
        do @(posedge hclk); while (hready !== 1'b1);
        rdata = hrdata;
        // stale data would hide a slave that samples too late
        hwdata <= ~wdata;
    endtask
endmodule

//--- verification/tb_top.sv
// Purpose: self-checking bench of the periodic interrupt timer
// Assumes: one wait state per access, byte address is four times the index
// Notes: read results are checked from a queue by a separate monitor
`timescale 1ns/1ns
`include "timer_defines.svh"

module tb_top;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic irq;
    int n_mismatch;
    int tests_run;
    int cycles;
    int code;
    int sh;
    logic rd_dphase;
    logic [32:0] note;
    logic [32:0] exp_q [$];
    logic [31:0] v;
    logic [15:0] cnt;
    logic [7:0] lim_h;
    logic [7:0] lim_l;
    logic [7:0] lo1;
    logic [7:0] reg_idx [7] = '{`IDX_STATUS_CONTROL, `IDX_COUNTER_HIGH, `IDX_COUNTER_LOW,
        `IDX_LIMIT_HIGH, `IDX_LIMIT_LOW, `IDX_EVENT_STATUS, `IDX_EVENT_MASK};
    logic [7:0] reg_rst [7] = '{`SC_RESET, 8'h00, 8'h00, `LIMIT_RESET, `LIMIT_RESET, 8'h00,
        `EV_MASK_RESET};

    periodic_interrupt_timer u_dut (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hreadyout(hreadyout),
        .hrdata(hrdata),
        .hresp(hresp),
        .irq(irq)
    );

    ahb_master u_master (
        .hclk(hclk),
        .hready(hreadyout),
        .hrdata(hrdata),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata)
    );

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    // ==========================================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        u_master.xfer(1'b1, {22'h0, idx, 2'h0}, {24'h0, d}, r);
    endtask

    // care low means the result is only used by the caller
    task automatic rd(input logic [7:0] idx, input logic care, input logic [7:0] e);
        exp_q.push_back({care, 24'h0, e});
        u_master.xfer(1'b0, {22'h0, idx, 2'h0}, 32'h0, v);
    endtask

    task automatic irq_is(input logic e);
        repeat (3) @(posedge hclk);
        check({31'h0, irq}, {31'h0, e});
    endtask

    task automatic reset_table();
        for (int i = 0; i < 7; i++) begin
            rd(reg_idx[i], 1'b1, reg_rst[i]);
        end
        irq_is(1'b0);
    endtask

    task automatic done_test(input string name);
        $display("test %0s finished", name);
    endtask

    // ==========================================================
    // read data monitor
    always @(posedge hclk) begin
        if (rd_dphase && hreadyout === 1'b1) begin
            note = exp_q.pop_front();
            check({31'h0, hresp}, 32'h0);
            if (note[32]) begin
                check(hrdata, note[31:0]);
            end
            rd_dphase = 1'b0;
        end
        if (hsel && htrans[1] && hreadyout && !hwrite) begin
            rd_dphase = 1'b1;
        end
    end

    always @(posedge hclk) begin
        cycles++;
        if (cycles == 40000) begin
            n_mismatch++;
            $display("mismatch at %0t: run did not finish", $time);
            summarize();
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        hresetn = 1'b0;
        n_mismatch = 0;
        tests_run = 0;
        cycles = 0;
        rd_dphase = 1'b0;
        void'($urandom(1336));
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        reset_table();
        done_test("reset values");
        wr(`IDX_COUNTER_HIGH, 8'h5a);
        wr(`IDX_COUNTER_LOW, 8'ha5);
        rd(`IDX_COUNTER_HIGH, 1'b1, 8'h00);
        rd(`IDX_COUNTER_LOW, 1'b1, 8'h00);
        wr(8'h60, 8'h77);
        rd(8'h60, 1'b1, 8'h00);
        wr(`IDX_STATUS_CONTROL, 8'hff);
        rd(`IDX_STATUS_CONTROL, 1'b1, 8'h67);
        wr(`IDX_STATUS_CONTROL, 8'h20);
        rd(`IDX_STATUS_CONTROL, 1'b1, 8'h20);
        done_test("access kinds");
        for (int i = 0; i < 4; i++) begin
            lim_h = 8'($urandom);
            lim_l = 8'($urandom);
            wr(`IDX_LIMIT_HIGH, lim_h);
            wr(`IDX_LIMIT_LOW, lim_l);
            rd(`IDX_LIMIT_HIGH, 1'b1, lim_h);
            rd(`IDX_LIMIT_LOW, 1'b1, lim_l);
        end
        wr(`IDX_LIMIT_HIGH, 8'hff);
        wr(`IDX_LIMIT_LOW, 8'hff);
        done_test("limit registers");
        // about 260 run cycles per code; a neighbouring divider lands outside the window
        for (code = 0; code < 8; code++) begin
            wr(`IDX_STATUS_CONTROL, 8'h30 | 8'(code));
            rd(`IDX_COUNTER_HIGH, 1'b1, 8'h00);
            rd(`IDX_COUNTER_LOW, 1'b1, 8'h00);
            wr(`IDX_STATUS_CONTROL, 8'(code));
            repeat (256) @(posedge hclk);
            wr(`IDX_STATUS_CONTROL, 8'h20 | 8'(code));
            rd(`IDX_COUNTER_HIGH, 1'b0, 8'h00);
            cnt[15:8] = v[7:0];
            rd(`IDX_COUNTER_LOW, 1'b0, 8'h00);
            cnt[7:0] = v[7:0];
            sh = (code > 6) ? 6 : code;
            check({31'h0, (cnt >= (256 >> sh)) && (cnt <= (264 >> sh) + 1)}, 32'h1);
        end
        done_test("prescaler");
        // the two latching high reads are 8 cycles apart; a high read while latched must not relatch
        wr(`IDX_STATUS_CONTROL, 8'h30);
        wr(`IDX_STATUS_CONTROL, 8'h00);
        rd(`IDX_COUNTER_HIGH, 1'b0, 8'h00);
        rd(`IDX_COUNTER_LOW, 1'b0, 8'h00);
        lo1 = v[7:0];
        rd(`IDX_COUNTER_HIGH, 1'b0, 8'h00);
        repeat (20) @(posedge hclk);
        rd(`IDX_COUNTER_HIGH, 1'b0, 8'h00);
        rd(`IDX_COUNTER_LOW, 1'b1, lo1 + 8'h08);
        wr(`IDX_STATUS_CONTROL, 8'h20);
        done_test("counter latch");
        wr(`IDX_STATUS_CONTROL, 8'h30);
        wr(`IDX_LIMIT_HIGH, 8'h00);
        wr(`IDX_LIMIT_LOW, 8'h03);
        wr(`IDX_STATUS_CONTROL, 8'h46);
        for (int i = 0; i < 400 && irq !== 1'b1; i++) @(posedge hclk);
        check({31'h0, irq}, 32'h1);
        rd(`IDX_STATUS_CONTROL, 1'b1, 8'hc6);
        // an overflow after the arming read must block the clear
        repeat (300) @(posedge hclk);
        wr(`IDX_STATUS_CONTROL, 8'h66);
        rd(`IDX_STATUS_CONTROL, 1'b1, 8'he6);
        // flag bit written as one, so the armed clear is dropped while the enable goes low
        wr(`IDX_STATUS_CONTROL, 8'ha6);
        irq_is(1'b0);
        wr(`IDX_STATUS_CONTROL, 8'h66);
        irq_is(1'b1);
        rd(`IDX_STATUS_CONTROL, 1'b1, 8'he6);
        wr(`IDX_STATUS_CONTROL, 8'h66);
        rd(`IDX_STATUS_CONTROL, 1'b1, 8'h66);
        irq_is(1'b0);
        done_test("overflow flag");
        rd(`IDX_EVENT_STATUS, 1'b1, 8'h03);
        rd(`IDX_EVENT_STATUS, 1'b1, 8'h00);
        wr(`IDX_EVENT_MASK, 8'h02);
        rd(`IDX_EVENT_MASK, 1'b1, 8'h02);
        wr(`IDX_STATUS_CONTROL, 8'h30);
        irq_is(1'b1);
        rd(`IDX_EVENT_STATUS, 1'b1, 8'h02);
        irq_is(1'b0);
        wr(`IDX_EVENT_MASK, 8'h00);
        wr(`IDX_STATUS_CONTROL, 8'h30);
        irq_is(1'b0);
        rd(`IDX_EVENT_STATUS, 1'b1, 8'h02);
        done_test("event interrupt");
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        reset_table();
        done_test("second reset");
        summarize();
    end
endmodule
